/* File: shared/adc_ctrl_regs.vh */
// Purpose: Register map, field positions, reset values and timing counts of the converter control
// Assumes: AHB-Lite slave with 32-bit data, one aligned word per register
// Notes:   Printed offsets are register indices; byte address is four times the index
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define IDX_RESULT_LOW       8'h04
`define IDX_RESULT_HIGH      8'h05
`define IDX_CTRL_STATUS      8'h06
`define IDX_INPUT_REF_SEL    8'h07
`define IDX_CORE_STATUS      8'h08

`define BIT_ENABLE           7
`define BIT_START            6
`define BIT_FREE_RUN         5
`define BIT_DONE_FLAG        4
`define BIT_DONE_IRQ_EN      3
`define BIT_LEFT_ADJUST      5

`define CTRL_STATUS_RESET    8'h00
`define INPUT_REF_RESET      8'h00

`define NORMAL_CONV_CLOCKS   8'h0d
`define EXTENDED_CONV_CLOCKS 8'h19
`define SAMPLE_NORMAL_CLOCK  8'h01
`define SAMPLE_EXT_CLOCK     8'h0d

`define CH_LAST_SINGLE       5'h0a
`define CH_BANDGAP           5'h1e
`define CH_GROUND            5'h1f

`endif

/* File: verilog/conv_clock_divider.v */
// Purpose: Prescaler that makes the converter clock tick from the system clock
// Assumes: Tick is a one-cycle pulse at the rising converter-clock edge
// Notes:   Divider restarts when the converter is off, so the first tick is predictable
`timescale 1ns/10ps

module conv_clock_divider (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       run,
	input  wire [2:0] prescale,
	output reg        tick
);

	reg  [6:0] count_reg;
	reg  [6:0] limit;

	always @* begin
		case (prescale)
			3'h0, 3'h1: limit = 7'h01;
			3'h2: limit = 7'h03;
			3'h3: limit = 7'h07;
			3'h4: limit = 7'h0f;
			3'h5: limit = 7'h1f;
			3'h6: limit = 7'h3f;
			default: limit = 7'h7f;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 7'h00;
			tick      <= 1'b0;
		end else if (!run) begin
			count_reg <= 7'h00;
			tick      <= 1'b0;
		end else if (count_reg >= limit) begin
			count_reg <= 7'h00;
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + 7'h01;
			tick      <= 1'b0;
		end
	end

endmodule // conv_clock_divider

/* File: verilog/adc_sequencer_control.v */
// Purpose: Control, sequencing and register logic of a 10-bit converter behind AHB-Lite
// Assumes: Analog core answers with a 10-bit result; core pins are synchronised here
// Notes:   Zero wait-state slave, OKAY always; unmapped words read zero, writes ignored
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"

module adc_sequencer_control (
	input  wire        CLK,
	input  wire        RSTN,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output reg  [31:0] HRDATA,
	output reg         HREADYOUT,
	output reg         HRESP,
	input  wire        GLOBAL_IRQ_ENABLE,
	input  wire        IRQ_VECTOR_ACK,
	input  wire [9:0]  CORE_RESULT,
	output reg         CORE_POWER,
	output reg         CORE_SAMPLE,
	output reg         CORE_CONVERT,
	output reg  [1:0]  CORE_REF_SELECT,
	output reg  [4:0]  CORE_POS_INPUT,
	output reg  [4:0]  CORE_NEG_INPUT,
	output reg         CORE_DIFFERENTIAL,
	output reg         CORE_GAIN_HIGH,
	output reg         CORE_BANDGAP,
	output reg         CORE_GROUND,
	output reg         CONV_DONE_IRQ
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_DUMMY = 3'b010;
	localparam [2:0] ST_CONV  = 3'b100;

	reg  [2:0]  state_reg;
	reg  [7:0]  clk_count_reg;
	reg         enable_reg;
	reg         start_reg;
	reg         free_run_reg;
	reg         done_flag_reg;
	reg         irq_en_reg;
	reg  [2:0]  prescale_reg;
	reg  [7:0]  mux_wr_reg;
	reg  [1:0]  ref_lock_reg;
	reg  [4:0]  chan_lock_reg;
	reg  [9:0]  result_reg;
	reg         first_pending_reg;
	reg  [9:0]  core_sync1_reg;
	reg  [9:0]  core_sync2_reg;
	reg         wr_pend_reg;
	reg         rd_pend_reg;
	reg  [7:0]  addr_idx_reg;

	wire        conv_tick;
	wire        addr_phase;
	wire        wr_ctrl;
	wire        wr_mux;
	wire [7:0]  wdata;
	wire        busy;
	wire [7:0]  conv_len;
	wire [7:0]  sample_at;
	wire        last_clock;
	wire        finishing;
	wire        start_req;
	wire        hold_sel;
	reg  [7:0]  ctrl_read;
	reg  [15:0] result_view;
	reg  [31:0] rdata_next;
	reg  [4:0]  pos_next;
	reg  [4:0]  neg_next;
	reg         gain_next;
	reg         diff_next;

	assign addr_phase = HSEL & HREADY & HTRANS[1];
	assign wdata      = HWDATA[7:0];
	assign wr_ctrl    = wr_pend_reg & (addr_idx_reg == `IDX_CTRL_STATUS);
	assign wr_mux     = wr_pend_reg & (addr_idx_reg == `IDX_INPUT_REF_SEL);
	assign busy       = ~state_reg[0];
	assign conv_len   = state_reg[1] ? `EXTENDED_CONV_CLOCKS : `NORMAL_CONV_CLOCKS;
	assign sample_at  = state_reg[1] ? `SAMPLE_EXT_CLOCK : `SAMPLE_NORMAL_CLOCK;
	assign last_clock = busy & (clk_count_reg == conv_len - 8'h01);
	assign finishing  = last_clock & conv_tick;
	assign start_req  = wr_ctrl & wdata[`BIT_START];
	assign hold_sel   = busy & ~last_clock;

	conv_clock_divider u_divider (
		.clk      (CLK),
		.rst_n    (RSTN),
		.run      (enable_reg),
		.prescale (prescale_reg),
		.tick     (conv_tick)
	);

	// Data phase bookkeeping; slave never stretches, so every transfer takes one data cycle
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend_reg  <= 1'b0;
			rd_pend_reg  <= 1'b0;
			addr_idx_reg <= 8'h00;
			HREADYOUT    <= 1'b1;
			HRESP        <= 1'b0;
		end else begin
			wr_pend_reg  <= addr_phase & HWRITE;
			rd_pend_reg  <= addr_phase & ~HWRITE;
			if (addr_phase)
				addr_idx_reg <= HADDR[9:2];
			HREADYOUT    <= 1'b1;
			HRESP        <= 1'b0;
		end
	end

	// Core result arrives from the analog domain
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			core_sync1_reg <= 10'h000;
			core_sync2_reg <= 10'h000;
		end else begin
			core_sync1_reg <= CORE_RESULT;
			core_sync2_reg <= core_sync1_reg;
		end
	end

	// Sequencer
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg         <= ST_IDLE;
			clk_count_reg     <= 8'h00;
			start_reg         <= 1'b0;
			first_pending_reg <= 1'b0;
			result_reg        <= 10'h000;
		end else if (!enable_reg || (wr_ctrl && !wdata[`BIT_ENABLE])) begin
			state_reg         <= ST_IDLE;
			clk_count_reg     <= 8'h00;
			// arm dummy on enable; a start written with it is kept
			start_reg         <= wr_ctrl & wdata[`BIT_ENABLE] & wdata[`BIT_START];
			first_pending_reg <= wr_ctrl & wdata[`BIT_ENABLE];
		end else begin
			if (start_req)
				start_reg <= 1'b1;
			case (state_reg)
				ST_IDLE: begin
					if ((start_reg || start_req) && conv_tick) begin
						state_reg         <= first_pending_reg ? ST_DUMMY : ST_CONV;
						first_pending_reg <= 1'b0;
						clk_count_reg     <= 8'h00;
					end
				end
				ST_DUMMY, ST_CONV: begin
					if (conv_tick)
						clk_count_reg <= clk_count_reg + 8'h01;
					if (finishing) begin
						clk_count_reg <= 8'h00;
						if (state_reg[1]) begin
							state_reg <= ST_CONV;
						end else begin
							result_reg <= core_sync2_reg;
							if (free_run_reg) begin
								state_reg <= ST_CONV;
							end else begin
								state_reg <= ST_IDLE;
								start_reg <= 1'b0;
							end
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Control and status register fields
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			enable_reg    <= 1'b0;
			free_run_reg  <= 1'b0;
			irq_en_reg    <= 1'b0;
			prescale_reg  <= 3'h0;
			done_flag_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				enable_reg   <= wdata[`BIT_ENABLE];
				free_run_reg <= wdata[`BIT_FREE_RUN];
				irq_en_reg   <= wdata[`BIT_DONE_IRQ_EN];
				prescale_reg <= wdata[2:0];
			end
			// set on completion, wins over clear
			if (finishing && state_reg[2] && enable_reg)
				done_flag_reg <= 1'b1;
			else if (wr_ctrl && wdata[`BIT_DONE_FLAG])
				done_flag_reg <= 1'b0;
			else if (IRQ_VECTOR_ACK)
				done_flag_reg <= 1'b0;
		end
	end

	// Selection: written value is the temporary copy, lock copy drives the core
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mux_wr_reg    <= `INPUT_REF_RESET;
			ref_lock_reg  <= 2'h0;
			chan_lock_reg <= 5'h00;
		end else begin
			if (wr_mux)
				mux_wr_reg <= wdata;
			if (!hold_sel) begin
				ref_lock_reg  <= mux_wr_reg[7:6];
				chan_lock_reg <= mux_wr_reg[4:0];
			end
		end
	end

	// single-ended and special codes; differential pairs with gain
	always @* begin
		pos_next  = 5'h00;
		neg_next  = 5'h00;
		gain_next = 1'b0;
		diff_next = 1'b0;
		if (chan_lock_reg <= `CH_LAST_SINGLE) begin
			pos_next = chan_lock_reg;
		end else if (chan_lock_reg < `CH_BANDGAP) begin
			diff_next = 1'b1;
			case (chan_lock_reg)
				5'h0b: begin pos_next = 5'h00; neg_next = 5'h01; gain_next = 1'b1; end
				5'h0c: begin pos_next = 5'h00; neg_next = 5'h01; end
				5'h0d: begin pos_next = 5'h01; neg_next = 5'h01; gain_next = 1'b1; end
				5'h0e: begin pos_next = 5'h02; neg_next = 5'h01; gain_next = 1'b1; end
				5'h0f: begin pos_next = 5'h02; neg_next = 5'h01; end
				5'h10: begin pos_next = 5'h02; neg_next = 5'h03; end
				5'h11: begin pos_next = 5'h03; neg_next = 5'h03; gain_next = 1'b1; end
				5'h12: begin pos_next = 5'h04; neg_next = 5'h03; gain_next = 1'b1; end
				5'h13: begin pos_next = 5'h04; neg_next = 5'h03; end
				5'h14: begin pos_next = 5'h04; neg_next = 5'h05; gain_next = 1'b1; end
				5'h15: begin pos_next = 5'h04; neg_next = 5'h05; end
				5'h16: begin pos_next = 5'h05; neg_next = 5'h05; gain_next = 1'b1; end
				5'h17: begin pos_next = 5'h06; neg_next = 5'h05; gain_next = 1'b1; end
				5'h18: begin pos_next = 5'h06; neg_next = 5'h05; end
				5'h19: begin pos_next = 5'h08; neg_next = 5'h09; gain_next = 1'b1; end
				5'h1a: begin pos_next = 5'h08; neg_next = 5'h09; end
				5'h1b: begin pos_next = 5'h09; neg_next = 5'h09; gain_next = 1'b1; end
				5'h1c: begin pos_next = 5'h0a; neg_next = 5'h09; gain_next = 1'b1; end
				default: begin pos_next = 5'h0a; neg_next = 5'h09; end
			endcase
		end
	end

	// Core drive; outputs registered so the core never sees decode glitches
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			CORE_POWER        <= 1'b0;
			CORE_SAMPLE       <= 1'b0;
			CORE_CONVERT      <= 1'b0;
			CORE_REF_SELECT   <= 2'h0;
			CORE_POS_INPUT    <= 5'h00;
			CORE_NEG_INPUT    <= 5'h00;
			CORE_DIFFERENTIAL <= 1'b0;
			CORE_GAIN_HIGH    <= 1'b0;
			CORE_BANDGAP      <= 1'b0;
			CORE_GROUND       <= 1'b0;
			CONV_DONE_IRQ     <= 1'b0;
		end else begin
			CORE_POWER        <= enable_reg;
			CORE_SAMPLE       <= busy & conv_tick & (clk_count_reg == sample_at);
			CORE_CONVERT      <= busy;
			CORE_REF_SELECT   <= ref_lock_reg;
			CORE_POS_INPUT    <= pos_next;
			CORE_NEG_INPUT    <= neg_next;
			CORE_DIFFERENTIAL <= diff_next;
			CORE_GAIN_HIGH    <= gain_next;
			CORE_BANDGAP      <= (chan_lock_reg == `CH_BANDGAP);
			CORE_GROUND       <= (chan_lock_reg == `CH_GROUND);
			CONV_DONE_IRQ     <= done_flag_reg & irq_en_reg & GLOBAL_IRQ_ENABLE;
		end
	end

	// adjust at read mux; immediate effect
	always @* begin
		if (mux_wr_reg[`BIT_LEFT_ADJUST])
			result_view = {result_reg, 6'h00};
		else
			result_view = {6'h00, result_reg};
		ctrl_read = {enable_reg, start_reg, free_run_reg, done_flag_reg,
		             irq_en_reg, prescale_reg};
		case (HADDR[9:2])
			`IDX_RESULT_LOW:    rdata_next = {24'h000000, result_view[7:0]};
			`IDX_RESULT_HIGH:   rdata_next = {24'h000000, result_view[15:8]};
			`IDX_CTRL_STATUS:   rdata_next = {24'h000000, ctrl_read};
			`IDX_INPUT_REF_SEL: rdata_next = {24'h000000, mux_wr_reg};
			`IDX_CORE_STATUS:   rdata_next = {29'h0000000, state_reg};
			default:            rdata_next = 32'h00000000;
		endcase
	end

	// Read data registered at the address phase, valid in the data phase
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			HRDATA <= 32'h00000000;
		else if (addr_phase && !HWRITE)
			HRDATA <= rdata_next;
	end

endmodule // adc_sequencer_control

/* File: bench/analog_core_model.sv */
// Purpose: Behavioural sample-and-hold and converter core
// Assumes: Result is {positive input, negative input} of the locked selection
// Notes:   Outside a conversion the result lines show the inverse, never a stale value
`timescale 1ns/10ps

module analog_core_model (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       sample,
	input  wire       convert,
	input  wire [4:0] pos_in,
	input  wire [4:0] neg_in,
	output wire [9:0] result
);
	logic [9:0] held_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			held_reg <= 10'h000;
		else if (sample)
			held_reg <= {pos_in, neg_in};
	end

	assign result = convert ? held_reg : ~held_reg;
endmodule // analog_core_model

/* File: bench/adc_seq_properties.sv */
// Purpose: Port-level checks of the converter control
// Assumes: Single AHB-Lite master, one clock domain
// Notes:   Control writes are tracked from address phase to data phase
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"

module adc_seq_properties (
	input wire        CLK,
	input wire        RSTN,
	input wire        HSEL,
	input wire [31:0] HADDR,
	input wire [1:0]  HTRANS,
	input wire        HWRITE,
	input wire [31:0] HWDATA,
	input wire        HREADY,
	input wire        HREADYOUT,
	input wire        HRESP,
	input wire        GLOBAL_IRQ_ENABLE,
	input wire        IRQ_VECTOR_ACK,
	input wire        CORE_POWER,
	input wire        CORE_SAMPLE,
	input wire        CORE_CONVERT,
	input wire [4:0]  CORE_POS_INPUT,
	input wire [4:0]  CORE_NEG_INPUT,
	input wire        CORE_DIFFERENTIAL,
	input wire        CORE_GAIN_HIGH,
	input wire        CORE_BANDGAP,
	input wire        CORE_GROUND,
	input wire        CONV_DONE_IRQ
);
	logic wr_ctrl_reg;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			wr_ctrl_reg <= 1'b0;
		else if (HREADY)
			wr_ctrl_reg <= HSEL && HTRANS[1] && HWRITE
				&& HADDR[9:2] == `IDX_CTRL_STATUS;
	end

	a_ready_high: assert property (HREADYOUT && !HRESP) else $error("bus not ready or error");
	a_power_on: assert property (wr_ctrl_reg && HWDATA[7] |-> ##[1:2] CORE_POWER)
		else $error("enable write did not power core");
	a_abort_off: assert property (wr_ctrl_reg && !HWDATA[7] |-> ##[1:3] !CORE_CONVERT)
		else $error("disable did not abort");
	a_sample_conv: assert property (CORE_SAMPLE |-> CORE_CONVERT ##1 !CORE_SAMPLE)
		else $error("sample strobe outside conversion");
	a_sample_locked: assert property (CORE_SAMPLE |-> $stable(CORE_POS_INPUT))
		else $error("selection moved at sample");
	a_single_neg: assert property (!CORE_DIFFERENTIAL |-> CORE_NEG_INPUT == 5'h00)
		else $error("single-ended with negative input");
	a_gain_diff: assert property (CORE_GAIN_HIGH |-> CORE_DIFFERENTIAL)
		else $error("gain without differential");
	a_offset_pair: assert property (CORE_DIFFERENTIAL && CORE_POS_INPUT == CORE_NEG_INPUT
		|-> CORE_GAIN_HIGH) else $error("offset pair not at high gain");
	a_ground_only: assert property (CORE_GROUND |-> !CORE_BANDGAP && !CORE_DIFFERENTIAL)
		else $error("ground with other source");
	a_irq_cause: assert property (CONV_DONE_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
		else $error("irq without global enable");
	a_ack_clears: assert property (IRQ_VECTOR_ACK && !CORE_CONVERT |-> ##[1:2] !CONV_DONE_IRQ)
		else $error("vector entry left irq");

	c_irq: cover property (CONV_DONE_IRQ);
	c_sample: cover property (CORE_SAMPLE);
	c_offset: cover property (CORE_DIFFERENTIAL && CORE_GAIN_HIGH);
endmodule // adc_seq_properties

bind adc_sequencer_control adc_seq_properties u_adc_seq_properties (.*);

/* File: bench/adc_sequencer_control_tb_top.sv */
// Purpose: Self-checking bench of the converter control
// Assumes: Zero wait-state slave; prescale kept small to keep runs short, except one t_codes pass at prescale 7
// Notes:   Cycle count of convert-high measures conversion length
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"

module adc_sequencer_control_tb_top;
	logic        CLK, RSTN, HSEL, HWRITE, GIE, ACK;
	logic [31:0] HADDR, HWDATA;
	logic [1:0]  HTRANS;
	wire  [31:0] HRDATA;
	wire         HREADYOUT, HRESP, PWR, SMP, CNV, DIF, GHI, BG, GND, IRQ;
	wire  [1:0]  REF;
	wire  [4:0]  POS, NEG;
	wire  [9:0]  RES;
	int          miscompares, checks_done, cyc, hi;
	logic [7:0]  q;

	adc_sequencer_control u_adc_sequencer_control (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.GLOBAL_IRQ_ENABLE(GIE), .IRQ_VECTOR_ACK(ACK), .CORE_RESULT(RES), .CORE_POWER(PWR),
		.CORE_SAMPLE(SMP), .CORE_CONVERT(CNV), .CORE_REF_SELECT(REF), .CORE_POS_INPUT(POS),
		.CORE_NEG_INPUT(NEG), .CORE_DIFFERENTIAL(DIF), .CORE_GAIN_HIGH(GHI),
		.CORE_BANDGAP(BG), .CORE_GROUND(GND), .CONV_DONE_IRQ(IRQ));
	analog_core_model u_analog_core_model (.clk(CLK), .rst_n(RSTN), .sample(SMP),
		.convert(CNV), .pos_in(POS), .neg_in(NEG), .result(RES));

	task summarize;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task bus(input [7:0] a, input w, input [7:0] d, output [7:0] r);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HWRITE <= w;
		HADDR <= {22'h0, a, 2'b00};
		@(posedge CLK);
		while (HREADYOUT !== 1'b1) @(posedge CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= {24'h0, d};
		@(posedge CLK);
		while (HREADYOUT !== 1'b1) @(posedge CLK);
		r = HRDATA[7:0];
	endtask

	// whole values only, never read-modify-write of control-status
	task wr(input [7:0] a, input [7:0] d);
		bus(a, 1'b1, d, q);
	endtask

	task rd(input [7:0] a);
		bus(a, 1'b0, 8'h00, q);
	endtask

	task wt;
		q = 8'h00;
		for (int i = 0; i < 1000 && q[`BIT_DONE_FLAG] !== 1'b1; i++) rd(`IDX_CTRL_STATUS);
	endtask

	task t_reset;
		rd(`IDX_CTRL_STATUS);
		chk("ctrl rst", 16'h0000, q);
		rd(`IDX_INPUT_REF_SEL);
		chk("sel rst", 16'h0000, q);
		rd(8'h10);
		chk("unmapped", 16'h0000, q);
	endtask

	task t_first;
		hi = 0;
		wr(`IDX_INPUT_REF_SEL, 8'h0b);
		wr(`IDX_CTRL_STATUS, 8'hc0);
		rd(`IDX_CTRL_STATUS);
		chk("start", 16'h0001, q[6]);
		repeat (50) @(posedge CLK);
		rd(`IDX_CTRL_STATUS);
		chk("start real", 16'h0001, q[6]);
		wt;
		chk("ctrl done", 16'h0090, q);
		chk("dummy len", 16'd76, hi);
		chk("diff 0-1", 16'h0007, {POS, NEG, DIF, GHI});
		rd(`IDX_RESULT_LOW);
		chk("right lo", 16'h0001, q);
		wr(`IDX_INPUT_REF_SEL, 8'h2b);
		rd(`IDX_RESULT_LOW);
		chk("left lo", 16'h0040, q);
		rd(`IDX_RESULT_HIGH);
		chk("left hi", 16'h0000, q);
		wr(`IDX_CTRL_STATUS, 8'h80);
		rd(`IDX_CTRL_STATUS);
		chk("zero keeps", 16'h0090, q);
		wr(`IDX_CTRL_STATUS, 8'h90);
		rd(`IDX_CTRL_STATUS);
		chk("one clears", 16'h0080, q);
	endtask

	task t_codes;
		logic [4:0]  cd[5];
		logic [13:0] ex[5];
		logic [2:0]  ps;
		cd = '{5'h03, 5'h0c, 5'h0d, 5'h1e, 5'h1f};
		ex = '{14'h0600, 14'h0018, 14'h021c, 14'h0002, 14'h0001};
		for (int i = 0; i < 5; i++) begin
			ps = (i == 4) ? 3'h7 : i[2:0];
			wr(`IDX_INPUT_REF_SEL, {i[1:0], 1'b0, cd[i]});
			wr(`IDX_CTRL_STATUS, 8'hc0 | ps);
			wt;
			// first result after a reference change is discarded
			hi = 0;
			wr(`IDX_CTRL_STATUS, 8'hd0 | ps);
			wt;
			chk("ref", i[1:0], REF);
			chk("decode", ex[i], {POS, NEG, DIF, GHI, BG, GND});
			chk("conv len", 13 * (ps < 2 ? 2 : 1 << ps), hi);
			rd(`IDX_RESULT_LOW);
			chk("result", ex[i][11:4], q);
			wr(`IDX_CTRL_STATUS, 8'h90);
		end
	endtask

	task t_lock;
		wr(`IDX_INPUT_REF_SEL, 8'h03);
		wr(`IDX_CTRL_STATUS, 8'hc3);
		// wait one converter clock before a new selection
		repeat (10) @(posedge CLK);
		wr(`IDX_INPUT_REF_SEL, 8'h05);
		chk("locked", 16'h03, POS);
		wr(`IDX_CTRL_STATUS, 8'h83);
		rd(`IDX_CTRL_STATUS);
		chk("zero start", 16'h0001, q[6]);
		wt;
		repeat (3) @(posedge CLK);
		chk("applied", 16'h05, POS);
		rd(`IDX_RESULT_LOW);
		chk("old sel", 16'h0060, q);
		wr(`IDX_CTRL_STATUS, 8'h93);
	endtask

	task t_abort;
		wr(`IDX_CTRL_STATUS, 8'hc3);
		repeat (10) @(posedge CLK);
		wr(`IDX_CTRL_STATUS, 8'h03);
		rd(`IDX_CTRL_STATUS);
		chk("aborted", 16'h0003, q);
		chk("conv off", 16'h0000, {PWR, CNV});
		hi = 0;
		wr(`IDX_CTRL_STATUS, 8'hc0);
		wt;
		chk("redo dummy", 16'd76, hi);
		wr(`IDX_CTRL_STATUS, 8'h90);
	endtask

	task t_free;
		wr(`IDX_CTRL_STATUS, 8'he0);
		wt;
		wr(`IDX_CTRL_STATUS, 8'hb0);
		wt;
		chk("free again", 16'h00f0, q);
		wr(`IDX_CTRL_STATUS, 8'h90);
		wt;
		chk("free ends", 16'h0090, q);
		wr(`IDX_CTRL_STATUS, 8'h90);
	endtask

	task t_irq;
		wr(`IDX_CTRL_STATUS, 8'hc8);
		wt;
		chk("irq masked", 16'h0000, IRQ);
		GIE <= 1'b1;
		repeat (3) @(posedge CLK);
		chk("irq on", 16'h0001, IRQ);
		ACK <= 1'b1;
		@(posedge CLK);
		ACK <= 1'b0;
		repeat (3) @(posedge CLK);
		chk("irq off", 16'h0000, IRQ);
		rd(`IDX_CTRL_STATUS);
		chk("ack clears", 16'h0088, q);
	endtask

	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (CNV === 1'b1)
			hi <= hi + 1;
		if (cyc == 20000) begin
			miscompares++;
			summarize;
		end
	end

	initial begin
		{RSTN, HSEL, HWRITE, GIE, ACK, HADDR, HWDATA, HTRANS} = '0;
		{miscompares, checks_done, cyc, hi} = '0;
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		t_reset;
		t_first;
		t_codes;
		t_lock;
		t_abort;
		t_free;
		t_irq;
		summarize;
	end
endmodule // adc_sequencer_control_tb_top
